// File: src/tlr_pkg.sv
// Purpose: Shared constants for the receive link configuration block
// Assumes: Register index times four gives the AXI4-Lite byte address
// Notes:   All widths and counts are fixed
package tlr_pkg;

	// ************************************************************
	// Sizes
	// ************************************************************
	localparam int          NUM_LINKS       = 16;
	localparam int          ADDR_W          = 16;
	localparam int          REG_W           = 16;
	localparam int          FPOS_W          = 11;

	// ************************************************************
	// Register indices and byte addresses
	// ************************************************************
	localparam logic [15:0] IDX_PLL_REF     = 16'h0634;
	localparam logic [15:0] IDX_RX_CTL_BASE = 16'h0700;
	localparam logic [15:0] IDX_AUTO_SYNC   = 16'h0741;
	localparam logic [15:0] ADDR_PLL_REF    = {IDX_PLL_REF[13:0], 2'b00};
	localparam logic [15:0] ADDR_RX_CTL     = {IDX_RX_CTL_BASE[13:0], 2'b00};
	localparam logic [15:0] ADDR_AUTO_SYNC  = {IDX_AUTO_SYNC[13:0], 2'b00};

	// ************************************************************
	// Reset values and masks
	// ************************************************************
	localparam logic [15:0] RST_PLL_REF     = 16'h0000;
	localparam logic [15:0] RST_RX_CTL      = 16'h0000;
	localparam logic [15:0] RST_AUTO_SYNC   = 16'h0000;
	localparam logic [15:0] MASK_PLL_REF    = 16'h001F;
	localparam logic [15:0] MASK_CTL_STORE  = 16'h0FFF;
	localparam logic [15:0] MASK_CTL_READ   = 16'h07FF;
	localparam logic [15:0] MASK_AUTO_SYNC  = 16'h00FF;

	// ************************************************************
	// Receive link control fields
	// ************************************************************
	localparam int          RC_AUTO         = 10;
	localparam int          RC_LOOP         = 8;
	localparam int          RC_EN           = 7;
	localparam int          RC_RATE_HI      = 6;
	localparam int          RC_RATE_LO      = 5;
	localparam int          RC_MUX_HI       = 4;
	localparam int          RC_MUX_LO       = 3;
	localparam int          RC_FMT          = 2;
	localparam int          RC_CPOL         = 1;
	localparam int          RC_SPOL         = 0;
	localparam int          PLL_SYNC_BIT    = 4;

	localparam logic [1:0]  RATE_1544       = 2'h0;
	localparam logic [1:0]  RATE_2048       = 2'h1;
	localparam logic [1:0]  RATE_4096       = 2'h2;
	localparam logic [1:0]  RATE_8192       = 2'h3;
	localparam logic [1:0]  MUX_NONE        = 2'h0;
	localparam logic [1:0]  MUX_TWO         = 2'h1;
	localparam logic [1:0]  MUX_FOUR        = 2'h2;

	// Last bit position of a frame at each line rate
	localparam logic [10:0] FLAST_1544      = 11'h0C0;
	localparam logic [10:0] FLAST_2048      = 11'h0FF;
	localparam logic [10:0] FLAST_4096      = 11'h1FF;
	localparam logic [10:0] FLAST_8192      = 11'h3FF;

	// ************************************************************
	// Bus answers and decode kinds
	// ************************************************************
	localparam logic [1:0]  RESP_OKAY       = 2'h0;
	localparam logic [1:0]  RESP_SLVERR     = 2'h2;
	localparam logic [1:0]  KIND_NONE       = 2'h0;
	localparam logic [1:0]  KIND_PLL        = 2'h1;
	localparam logic [1:0]  KIND_CTL        = 2'h2;
	localparam logic [1:0]  KIND_AUTO       = 2'h3;

endpackage

// File: src/tlr_link_if.sv
// Purpose: Carrier between the system side and one receive link
// Assumes: cfg is only taken by the link while its enable is low
// Notes:   byte_tgl flips once per received byte
`timescale 1ns/10ps
interface tlr_link_if;
	logic [15:0] cfg;
	logic        en;
	logic [7:0]  rx_byte;
	logic [1:0]  sublink;
	logic        frame_start;
	logic        byte_tgl;

	modport sys  (output cfg, output en, input rx_byte, input sublink,
	              input frame_start, input byte_tgl);
	modport link (input cfg, input en, output rx_byte, output sublink,
	              output frame_start, output byte_tgl);
endinterface

// File: src/tlr_rx_link.sv
// Purpose: Receive front end of one link, on the link clock
// Assumes: Sync and data pins change with the link clock
// Notes:   Config is frozen while enabled; toggle it off to change it
`timescale 1ns/10ps
module tlr_rx_link (
	input  wire logic lclk,
	input  wire logic sync_pin,
	input  wire logic data_pin,
	tlr_link_if.link  lk
);

	logic        en_s1_r;
	logic        en_s2_r;
	logic [15:0] cfg_r;
	logic        d_neg_r;
	logic        s_neg_r;
	logic        phase_r;
	logic [2:0]  bit_cnt_r;
	logic [7:0]  shift_r;
	logic [10:0] fpos_r;
	logic [1:0]  sub_r;
	logic        first_r;
	logic [7:0]  byte_r;
	logic [1:0]  sublink_r;
	logic        fs_r;
	logic        tgl_r;
	logic        stbus;
	logic        fall;
	logic        bit_in;
	logic        sync_in;
	logic        sync_use;
	logic        strobe;
	logic [10:0] flast;
	logic [1:0]  sub_nxt;
	logic [7:0]  shift_nxt;

	assign lk.rx_byte     = byte_r;
	assign lk.sublink     = sublink_r;
	assign lk.frame_start = fs_r;
	assign lk.byte_tgl    = tgl_r;

	// ************************************************************
	// Enable crossing and config capture
	// ************************************************************
	always_ff @(posedge lclk) begin
		en_s1_r <= lk.en;
		en_s2_r <= en_s1_r;
	end

	// Capture only while disabled, so a word never crosses mid-change
	always_ff @(posedge lclk) begin
		if (!en_s2_r) begin
			cfg_r <= lk.cfg;
		end
	end

	always_ff @(negedge lclk) begin
		d_neg_r <= data_pin;
		s_neg_r <= sync_pin;
	end

	// ************************************************************
	// Format decode
	// ************************************************************
	always_comb begin
		stbus    = cfg_r[tlr_pkg::RC_FMT];
		// edge choice ignored in bus format
		fall     = !stbus && cfg_r[tlr_pkg::RC_CPOL];
		bit_in   = fall ? d_neg_r : data_pin;
		sync_in  = fall ? s_neg_r : sync_pin;
		sync_use = stbus ? !sync_in : (cfg_r[tlr_pkg::RC_SPOL] ? sync_in : !sync_in);
		// sync pin ignored in auto mode
		sync_use = sync_use && !cfg_r[tlr_pkg::RC_AUTO];
		// bus format clock at twice the bit rate
		strobe   = !stbus || phase_r || sync_use;
		shift_nxt = {shift_r[6:0], bit_in};
		unique case (cfg_r[tlr_pkg::RC_RATE_HI:tlr_pkg::RC_RATE_LO])
			tlr_pkg::RATE_1544: flast = tlr_pkg::FLAST_1544;
			tlr_pkg::RATE_2048: flast = tlr_pkg::FLAST_2048;
			tlr_pkg::RATE_4096: flast = tlr_pkg::FLAST_4096;
			tlr_pkg::RATE_8192: flast = tlr_pkg::FLAST_8192;
		endcase
		sub_nxt = 2'h0;
		if (stbus && cfg_r[tlr_pkg::RC_MUX_HI:tlr_pkg::RC_MUX_LO] == tlr_pkg::MUX_TWO) begin
			sub_nxt = {1'b0, !sub_r[0]};
		end else if (stbus && cfg_r[tlr_pkg::RC_MUX_HI:tlr_pkg::RC_MUX_LO] == tlr_pkg::MUX_FOUR) begin
			sub_nxt = sub_r + 2'h1;
		end
	end

	always_ff @(posedge lclk) begin
		if (!en_s2_r || !stbus || sync_use) begin
			phase_r <= 1'b0;
		end else begin
			phase_r <= !phase_r;
		end
	end

	// ************************************************************
	// Bit and byte assembly
	// ************************************************************
	// disabled link clears its counters
	always_ff @(posedge lclk) begin
		if (!en_s2_r) begin
			bit_cnt_r <= 3'h0;
			fpos_r    <= 11'h000;
			sub_r     <= 2'h0;
			first_r   <= 1'b1;
		end else if (strobe) begin
			shift_r <= shift_nxt;
			if (sync_use) begin
				bit_cnt_r <= 3'h1;
				fpos_r    <= 11'h001;
				sub_r     <= 2'h0;
				first_r   <= 1'b1;
			end else begin
				fpos_r <= (fpos_r == flast) ? 11'h000 : fpos_r + 11'h001;
				if (bit_cnt_r == 3'h7) begin
					bit_cnt_r <= 3'h0;
					sub_r     <= sub_nxt;
					first_r   <= 1'b0;
				end else begin
					bit_cnt_r <= bit_cnt_r + 3'h1;
				end
				if (fpos_r == flast) begin
					bit_cnt_r <= 3'h0;
					sub_r     <= 2'h0;
					first_r   <= 1'b1;
				end
			end
		end
	end

	// Byte is held steady until the next one, which the far side relies on
	// Toggle is cleared while disabled, so it never starts unknown
	always_ff @(posedge lclk) begin
		if (!en_s2_r) begin
			tgl_r <= 1'b0;
		end else if (strobe && !sync_use && bit_cnt_r == 3'h7) begin
			byte_r    <= shift_nxt;
			sublink_r <= sub_r;
			fs_r      <= first_r;
			tgl_r     <= !tgl_r;
		end
	end

endmodule

// File: src/tlr_rx_top.sv
// Purpose: Receive link configuration, PLL reference select, AXI4-Lite slave
// Assumes: Link clock, sync and data pins are unrelated to aclk
// Notes:   Received bytes are handed out one per cycle by a round-robin scan
//
// Functional notes
// - The five-bit select picks link receive clocks 0-15 or receive syncs 0-15 for the PLL.
// - Bits 15 to 5 of the PLL select register always read as zero.
// - Bit 10 makes the link ignore its sync pin so its counters free-run; the auto sync register is stored and read back only.
// - Bit 8 takes clock, sync and data from the same link's transmit pins instead.
// - Bit 7 turns the receive port of the link on or off.
// - The two-bit rate field picks 1.544, 2.048, 4.096 or 8.192 Mb/s.
// - The multiplex field splits a link bytewise into two or four, only in bus format.
// - Bit 2 picks generic format with a bit-rate clock or bus format with a double clock.
// - In generic format bit 1 picks rising or falling edge sampling of data.
// - In generic format bit 0 picks active low or active high sync.
`timescale 1ns/10ps
module tlr_rx_top (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [15:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [15:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic [15:0] receive_link_clock,
	input  wire logic [15:0] receive_frame_sync,
	input  wire logic [15:0] receive_serial_input,
	input  wire logic [15:0] transmit_link_clock,
	input  wire logic [15:0] transmit_frame_sync,
	input  wire logic [15:0] transmit_serial_output,
	output logic             pll_reference_input,
	output logic             rx_byte_valid,
	output logic [7:0]       rx_byte_data,
	output logic [3:0]       rx_byte_link,
	output logic [1:0]       rx_byte_sublink,
	output logic             rx_byte_frame_start
);

	localparam int N = tlr_pkg::NUM_LINKS;

	logic [15:0] pll_sel_r;
	logic [15:0] auto_sync_r;
	logic [15:0] ctl_r [N];
	logic        awready_r;
	logic        wready_r;
	logic        aw_hold_r;
	logic        w_hold_r;
	logic [15:0] awaddr_r;
	logic [15:0] wdata_r;
	logic [1:0]  wstrb_r;
	logic        bvalid_r;
	logic [1:0]  bresp_r;
	logic        arready_r;
	logic        rvalid_r;
	logic [31:0] rdata_r;
	logic [1:0]  rresp_r;
	logic [31:0] ref_s1_r;
	logic [31:0] ref_s2_r;
	logic        pll_ref_r;
	logic [N-1:0] evt;
	logic [N-1:0] pend_r;
	logic [7:0]  cap_byte_r [N];
	logic [1:0]  cap_sub_r [N];
	logic        cap_fs_r [N];
	logic [7:0]  lk_byte [N];
	logic [1:0]  lk_sub [N];
	logic        lk_fs [N];
	logic [3:0]  ptr_r;
	logic        out_valid_r;
	logic [7:0]  out_byte_r;
	logic [3:0]  out_link_r;
	logic [1:0]  out_sub_r;
	logic        out_fs_r;
	logic        wr_go;
	logic [1:0]  wr_kind;
	logic [1:0]  rd_kind;

	assign s_axi_awready       = awready_r;
	assign s_axi_wready        = wready_r;
	assign s_axi_bvalid        = bvalid_r;
	assign s_axi_bresp         = bresp_r;
	assign s_axi_arready       = arready_r;
	assign s_axi_rvalid        = rvalid_r;
	assign s_axi_rdata         = rdata_r;
	assign s_axi_rresp         = rresp_r;
	assign pll_reference_input = pll_ref_r;
	assign rx_byte_valid       = out_valid_r;
	assign rx_byte_data        = out_byte_r;
	assign rx_byte_link        = out_link_r;
	assign rx_byte_sublink     = out_sub_r;
	assign rx_byte_frame_start = out_fs_r;

	// ************************************************************
	// Address decode
	// ************************************************************
	function automatic logic [1:0] reg_kind(input logic [15:0] a);
		if (a[1:0] != 2'h0) begin
			return tlr_pkg::KIND_NONE;
		end else if (a == tlr_pkg::ADDR_PLL_REF) begin
			return tlr_pkg::KIND_PLL;
		end else if (a[15:6] == tlr_pkg::ADDR_RX_CTL[15:6]) begin
			return tlr_pkg::KIND_CTL;
		end else if (a == tlr_pkg::ADDR_AUTO_SYNC) begin
			return tlr_pkg::KIND_AUTO;
		end
		return tlr_pkg::KIND_NONE;
	endfunction

	function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] wd,
	                                      input logic [1:0] st, input logic [15:0] mask);
		logic [15:0] v;
		v = {st[1] ? wd[15:8] : old[15:8], st[0] ? wd[7:0] : old[7:0]};
		return v & mask;
	endfunction

	assign wr_kind = reg_kind(awaddr_r);
	assign rd_kind = reg_kind(s_axi_araddr);
	assign wr_go   = aw_hold_r && w_hold_r && !bvalid_r;

	// ************************************************************
	// AXI4-Lite write channel
	// ************************************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_r <= 1'b0;
			aw_hold_r <= 1'b0;
			awaddr_r  <= 16'h0000;
		end else if (s_axi_awvalid && awready_r) begin
			awready_r <= 1'b0;
			aw_hold_r <= 1'b1;
			awaddr_r  <= s_axi_awaddr;
		end else if (bvalid_r && s_axi_bready) begin
			aw_hold_r <= 1'b0;
		end else if (!aw_hold_r && !bvalid_r) begin
			awready_r <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wready_r <= 1'b0;
			w_hold_r <= 1'b0;
			wdata_r  <= 16'h0000;
			wstrb_r  <= 2'h0;
		end else if (s_axi_wvalid && wready_r) begin
			wready_r <= 1'b0;
			w_hold_r <= 1'b1;
			wdata_r  <= s_axi_wdata[15:0];
			wstrb_r  <= s_axi_wstrb[1:0];
		end else if (bvalid_r && s_axi_bready) begin
			w_hold_r <= 1'b0;
		end else if (!w_hold_r && !bvalid_r) begin
			wready_r <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_r <= 1'b0;
			bresp_r  <= tlr_pkg::RESP_OKAY;
		end else if (wr_go) begin
			bvalid_r <= 1'b1;
			bresp_r  <= (wr_kind == tlr_pkg::KIND_NONE) ? tlr_pkg::RESP_SLVERR
			                                            : tlr_pkg::RESP_OKAY;
		end else if (s_axi_bready) begin
			bvalid_r <= 1'b0;
		end
	end

	// ************************************************************
	// Register storage
	// ************************************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pll_sel_r   <= tlr_pkg::RST_PLL_REF;
			auto_sync_r <= tlr_pkg::RST_AUTO_SYNC;
			for (int i = 0; i < N; i++) begin
				ctl_r[i] <= tlr_pkg::RST_RX_CTL;
			end
		end else if (wr_go) begin
			if (wr_kind == tlr_pkg::KIND_PLL) begin
				pll_sel_r <= merge(pll_sel_r, wdata_r, wstrb_r, tlr_pkg::MASK_PLL_REF);
			end
			if (wr_kind == tlr_pkg::KIND_AUTO) begin
				auto_sync_r <= merge(auto_sync_r, wdata_r, wstrb_r, tlr_pkg::MASK_AUTO_SYNC);
			end
			if (wr_kind == tlr_pkg::KIND_CTL) begin
				ctl_r[awaddr_r[5:2]] <= merge(ctl_r[awaddr_r[5:2]], wdata_r, wstrb_r,
				                              tlr_pkg::MASK_CTL_STORE);
			end
		end
	end

	// ************************************************************
	// AXI4-Lite read channel
	// ************************************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_r <= 1'b0;
			rvalid_r  <= 1'b0;
			rdata_r   <= 32'h00000000;
			rresp_r   <= tlr_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && arready_r) begin
			arready_r <= 1'b0;
			rvalid_r  <= 1'b1;
			rresp_r   <= tlr_pkg::RESP_OKAY;
			unique case (rd_kind)
				tlr_pkg::KIND_PLL:  rdata_r <= {16'h0000, pll_sel_r & tlr_pkg::MASK_PLL_REF};
				// write-only and unused bits read zero
				tlr_pkg::KIND_CTL:  rdata_r <= {16'h0000,
				                                ctl_r[s_axi_araddr[5:2]] & tlr_pkg::MASK_CTL_READ};
				tlr_pkg::KIND_AUTO: rdata_r <= {16'h0000, auto_sync_r};
				tlr_pkg::KIND_NONE: begin
					rdata_r <= 32'h00000000;
					rresp_r <= tlr_pkg::RESP_SLVERR;
				end
			endcase
		end else if (rvalid_r && s_axi_rready) begin
			rvalid_r <= 1'b0;
		end else if (!rvalid_r) begin
			arready_r <= 1'b1;
		end
	end

	// ************************************************************
	// PLL reference source
	// ************************************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ref_s1_r  <= 32'h00000000;
			ref_s2_r  <= 32'h00000000;
			pll_ref_r <= 1'b0;
		end else begin
			ref_s1_r  <= {receive_frame_sync, receive_link_clock};
			ref_s2_r  <= ref_s1_r;
			// low codes clocks, high codes syncs
			pll_ref_r <= ref_s2_r[pll_sel_r[tlr_pkg::PLL_SYNC_BIT:0]];
		end
	end

	// ************************************************************
	// Per-link front ends and crossings
	// ************************************************************
	for (genvar g = 0; g < N; g++) begin : g_link
		tlr_link_if lif ();
		logic lclk;
		logic lsync;
		logic ldata;
		logic tgl_s1_r;
		logic tgl_s2_r;
		logic tgl_s3_r;

		assign lclk  = ctl_r[g][tlr_pkg::RC_LOOP] ? transmit_link_clock[g]
		                                          : receive_link_clock[g];
		assign lsync = ctl_r[g][tlr_pkg::RC_LOOP] ? transmit_frame_sync[g]
		                                          : receive_frame_sync[g];
		assign ldata = ctl_r[g][tlr_pkg::RC_LOOP] ? transmit_serial_output[g]
		                                          : receive_serial_input[g];
		assign lif.cfg = ctl_r[g];
		assign lif.en  = ctl_r[g][tlr_pkg::RC_EN];
		assign lk_byte[g] = lif.rx_byte;
		assign lk_sub[g]  = lif.sublink;
		assign lk_fs[g]   = lif.frame_start;
		assign evt[g]     = tgl_s2_r ^ tgl_s3_r;

		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				tgl_s1_r <= 1'b0;
				tgl_s2_r <= 1'b0;
				tgl_s3_r <= 1'b0;
			end else begin
				tgl_s1_r <= lif.byte_tgl;
				tgl_s2_r <= tgl_s1_r;
				tgl_s3_r <= tgl_s2_r;
			end
		end

		tlr_rx_link u_link (
			.lclk     (lclk),
			.sync_pin (lsync),
			.data_pin (ldata),
			.lk       (lif.link)
		);
	end

	// ************************************************************
	// Pending bytes and round-robin hand-out
	// ************************************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pend_r <= '0;
		end else begin
			for (int i = 0; i < N; i++) begin
				if (!ctl_r[i][tlr_pkg::RC_EN]) begin
					pend_r[i] <= 1'b0;
				end else begin
					// New byte wins over the hand-out clear
					pend_r[i] <= evt[i] || (pend_r[i] && ptr_r != 4'(i));
				end
			end
		end
	end

	always_ff @(posedge aclk) begin
		for (int i = 0; i < N; i++) begin
			if (evt[i]) begin
				cap_byte_r[i] <= lk_byte[i];
				cap_sub_r[i]  <= lk_sub[i];
				cap_fs_r[i]   <= lk_fs[i];
			end
		end
	end

	// Scan visits every link within 16 cycles, far faster than a byte time
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ptr_r       <= 4'h0;
			out_valid_r <= 1'b0;
			out_byte_r  <= 8'h00;
			out_link_r  <= 4'h0;
			out_sub_r   <= 2'h0;
			out_fs_r    <= 1'b0;
		end else begin
			ptr_r       <= ptr_r + 4'h1;
			out_valid_r <= pend_r[ptr_r] && ctl_r[ptr_r][tlr_pkg::RC_EN];
			if (pend_r[ptr_r]) begin
				out_byte_r <= cap_byte_r[ptr_r];
				out_link_r <= ptr_r;
				out_sub_r  <= cap_sub_r[ptr_r];
				out_fs_r   <= cap_fs_r[ptr_r];
			end
		end
	end

endmodule

// File: verif/tlr_rx_top_chk.sv
// Purpose: Register bus checks for the receive link block
// Assumes: Fixed answers: write response two cycles, read data one cycle
// Notes:   Link traffic is judged by the bench
`timescale 1ns/10ps
module tlr_rx_top_chk (
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [15:0] s_axi_araddr,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready
);
	// ******
	// Checks
	// ******
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence s_wtake;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_rtake;
		s_axi_arvalid && s_axi_arready;
	endsequence
	property p_b_after; s_wtake |=> ##1 s_axi_bvalid; endproperty
	property p_b_done; s_axi_bvalid && s_axi_bready |=> !s_axi_awready ##1 s_axi_awready; endproperty
	property p_r_after; s_rtake |=> s_axi_rvalid; endproperty
	property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	property p_r_done; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid ##1 s_axi_arready; endproperty
	property p_pll_rd; s_rtake ##0 s_axi_araddr == tlr_pkg::ADDR_PLL_REF
		|=> s_axi_rdata[15:5] == 11'h000; endproperty
	property p_ctl_rd; s_rtake ##0 s_axi_araddr[15:6] == tlr_pkg::ADDR_RX_CTL[15:6]
		|=> s_axi_rdata[15:11] == 5'h00; endproperty
	property p_misal; s_rtake ##0 s_axi_araddr[1:0] != 2'h0
		|=> s_axi_rresp == tlr_pkg::RESP_SLVERR && s_axi_rdata == 32'h00000000; endproperty
	a_b_after: assert property (p_b_after) else $error("write answer late");
	a_b_done: assert property (p_b_done) else $error("write ready recovery wrong");
	a_r_after: assert property (p_r_after) else $error("read answer late");
	a_r_hold: assert property (p_r_hold) else $error("read data dropped");
	a_r_done: assert property (p_r_done) else $error("read ready recovery wrong");
	a_pll_rd: assert property (p_pll_rd) else $error("select upper bits set");
	a_ctl_rd: assert property (p_ctl_rd) else $error("control upper bits set");
	a_misal: assert property (p_misal) else $error("misaligned read accepted");
endmodule
bind tlr_rx_top tlr_rx_top_chk chk (.*);

// File: verif/tlr_framer_model.sv
// Purpose: Framer driving one receive link, generic format
// Assumes: Link clock period 30 ns
// Notes:   Clock stands still between frames
`timescale 1ns/10ps
module tlr_framer_model (
	output logic ck,
	output logic sy,
	output logic dt
);
	// *****
	// Frame
	// *****
	initial begin
		ck = 1'b0;
		sy = 1'b0;
		dt = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n) begin
			#15 ck = 1'b1;
			#15 ck = 1'b0;
		end
	endtask
	task automatic send(input logic [7:0] b, input logic pol, input logic fall);
		sy = ~pol;
		tick(4);
		for (int i = 7; i >= 0; i--) begin
			// Falling mode rises first, so no zero-width pulse follows a tick
			if (fall) #15 ck = 1'b1;
			if (fall) #1;
			dt = b[i];
			sy = (i == 7) ? pol : ~pol;
			if (fall) #14 ck = 1'b0;
			else #15 ck = 1'b1;
			if (!fall) #15 ck = 1'b0;
		end
		if (fall) #1;
		// Released line shows the inverse
		dt = ~b[0];
		sy = ~pol;
		tick(3);
	endtask
endmodule

// File: verif/tlr_rx_top_tb_top.sv
// Purpose: Bus and link tests for the receive link block
// Assumes: Link 0 carries the link traffic
// Notes:   Other links see static select patterns only
`timescale 1ns/10ps
module tlr_rx_top_tb_top;
	logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, lb;
	logic        s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic        s_axi_arready, s_axi_rvalid, pll_reference_input, mck, msy, mdt;
	logic        rx_byte_valid, rx_byte_frame_start;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rx_byte_sublink, r;
	logic [3:0]  s_axi_wstrb, rx_byte_link;
	logic [7:0]  rx_byte_data;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [15:0] s_axi_awaddr, s_axi_araddr, pat_ck, pat_sy, d, p;
	logic [15:0] receive_link_clock, receive_frame_sync, receive_serial_input;
	logic [15:0] transmit_link_clock, transmit_frame_sync, transmit_serial_output;
	int          errors, compares, cyc;
	assign receive_link_clock = pat_ck | {15'h0000, mck & ~lb};
	assign receive_frame_sync = pat_sy | {15'h0000, msy & ~lb};
	assign receive_serial_input = {15'h0000, mdt ^ lb};
	assign transmit_link_clock = {15'h0000, mck & lb};
	assign transmit_frame_sync = {15'h0000, msy & lb};
	assign transmit_serial_output = {15'h0000, mdt ^ ~lb};
	tlr_rx_top uut (.*);
	tlr_framer_model fm (.ck(mck), .sy(msy), .dt(mdt));
	// *****
	// Tasks
	// *****
	always #2 aclk = ~aclk;
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 10000) begin
			errors++;
			final_report();
		end
	end
	task automatic final_report();
		if (errors == 0 && compares > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		compares++;
		if (g !== e) begin
			errors++;
			$display("[FAIL] %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [15:0] a, input logic [15:0] v);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {16'h0000, v};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
	endtask
	task automatic rd(input logic [15:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata[15:0];
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	task automatic regt(input logic [15:0] a, input logic [15:0] w, input logic [15:0] e);
		rd(a);
		chk("reset", 16'h0000, d);
		wr(a, w);
		rd(a);
		chk("mask", e, d);
		wr(a, 16'h0000);
	endtask
	// Config is only taken while disabled, so ticks run in between
	task automatic link(input logic [15:0] c, input logic l, f, pl, en);
		logic [15:0] v;
		logic        got;
		got = 1'b0;
		v = 16'h0000;
		wr(tlr_pkg::ADDR_RX_CTL, 16'h0000);
		@(posedge aclk);
		lb <= 1'b0;
		fm.tick(4);
		@(posedge aclk);
		lb <= l;
		wr(tlr_pkg::ADDR_RX_CTL, c);
		fork
			fm.send(c[7:0] ^ 8'hA5, pl, f);
			repeat (300) begin
				@(posedge aclk);
				if (rx_byte_valid === 1'b1 && !got) begin
					got = 1'b1;
					v = {1'b0, rx_byte_frame_start, rx_byte_sublink, rx_byte_link, rx_byte_data};
				end
			end
		join
		chk("seen", {15'h0000, en}, {15'h0000, got});
		if (en) chk("byte", {8'h40, c[7:0] ^ 8'hA5}, v);
	endtask
	// *****
	// Tests
	// *****
	initial begin
		{aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, lb} = 6'h00;
		{s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 34'h000000000;
		{pat_ck, pat_sy, s_axi_wdata} = 64'h0000000000000000;
		s_axi_wstrb = 4'h3;
		{errors, compares, cyc} = 96'h0;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		regt(tlr_pkg::ADDR_PLL_REF, 16'hFFFF, 16'h001F);
		regt(tlr_pkg::ADDR_RX_CTL + 16'h0004, 16'hF56F, 16'h056F);
		regt(tlr_pkg::ADDR_AUTO_SYNC, 16'hFFFF, 16'h00FF);
		rd(tlr_pkg::ADDR_PLL_REF + 16'h0002);
		chk("resp", {14'h0000, tlr_pkg::RESP_SLVERR}, {14'h0000, r});
		for (int c = 0; c < 32; c++) begin
			wr(tlr_pkg::ADDR_PLL_REF, 16'(c));
			for (int v = 0; v < 2; v++) begin
				p = 16'h0001 << c[3:0];
				if (v == 0) p = ~p;
				@(posedge aclk);
				pat_ck <= c[4] ? ~p : p;
				pat_sy <= c[4] ? p : ~p;
				repeat (6) @(posedge aclk);
				chk("pll", 16'(v), {15'h0000, pll_reference_input});
			end
		end
		pat_ck <= 16'h0000;
		pat_sy <= 16'h0000;
		link(16'h0081, 1'b0, 1'b0, 1'b1, 1'b1);
		link(16'h0082, 1'b0, 1'b1, 1'b0, 1'b1);
		link(16'h0181, 1'b1, 1'b0, 1'b1, 1'b1);
		link(16'h0001, 1'b0, 1'b0, 1'b1, 1'b0);
		final_report();
	end
endmodule
